/* File: rtl/pwc_channels.sv */
// Four pulse-width channels with their APB register file.
// Assumes the shared time base count, period and restart pulse come
// from a timer block on pclk.
//
// Operation
// R1 - Enable bit 7 runs the channel
// R2 - Bit 6 lets the channel drive its pin
// R3 - Bit 5 reads output, read-only, resets zero
// R4 - Bit 4 set makes output active low
// R5 - Control bits 3..0 read zero, ignore writes
// R6 - Control bits clear on every reset
// R7 - Duty high holds eight upper duty bits
// R8 - Duty low bits 7..6 hold lower bits
// R9 - Duty bits survive reset, start unknown
// R10 - Shared period and count, per-channel registers
// R11 - Set on restart, clear at duty match
// R12 - Duty copied to buffer at period match
// R13 - Duty at or above period never clears
// R14 - Zero duty keeps output inactive
// R15 - Polarity after compare; disabled means inactive
//
// Local design decisions: the APB interface to the registers and the address map.

`timescale 1ns/1ps

module pwc_channels (
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output      logic [31:0] prdata,
    output      logic        pready,
    output      logic        pslverr,
    // Shared time base
    input  wire logic [9:0]  tb_count,
    input  wire logic [7:0]  tb_period,
    input  wire logic        tb_restart,
    // Channel pins
    output      logic [3:0]  pwm_pin_out,
    output      logic [3:0]  pwm_pin_oe
);

    ////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [3:0]  en;
        logic [3:0]  oe;
        logic [3:0]  inv;
        logic [3:0]  raw;
        logic [3:0]  pin;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } pwc_state_t;

    // Duty storage is kept across reset
    typedef struct packed {
        logic [3:0][7:0] dch;
        logic [3:0][1:0] dcl;
        logic [3:0][9:0] dbuf;
    } pwc_keep_t;

    pwc_state_t st_ff;
    pwc_state_t nxt_st;
    pwc_keep_t  kp_ff;
    pwc_keep_t  nxt_kp;

    logic                access;
    logic                first;
    logic                commit;
    logic [1:0]          ch;
    pwc_pkg::pwc_kind_t  kind;
    logic [10:0]         limit;
    logic [3:0]          full;
    logic [3:0][9:0]     new_duty;

    ////////////////////////////////////////////////////////////////////
    // Address decode

    function automatic pwc_pkg::pwc_kind_t reg_kind(
        input logic [11:0] a
    );
        pwc_pkg::pwc_kind_t k;
        k = pwc_pkg::KIND_NONE;
        if (a[11:6] == 6'h00) begin
            case (a[3:0])
                pwc_pkg::OFS_CTRL: k = pwc_pkg::KIND_CTRL;
                pwc_pkg::OFS_DCH:  k = pwc_pkg::KIND_DCH;
                pwc_pkg::OFS_DCL:  k = pwc_pkg::KIND_DCL;
                default:           k = pwc_pkg::KIND_NONE;
            endcase
        end
        return k;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        nxt_st = st_ff;
        nxt_kp = kp_ff;
        access = psel & penable;
        first  = access & ~st_ff.pready;
        commit = access & st_ff.pready;
        ch     = paddr[5:4];
        kind   = reg_kind(paddr);
        // Full period length is four times period plus four
        limit  = {1'b0, tb_period, 2'b11} + 11'h001;

        // One wait state, answer registered
        nxt_st.pready  = first;
        nxt_st.pslverr = 1'b0;
        nxt_st.prdata  = pwc_pkg::RDATA_RST; // R5
        if (first) begin
            case (kind)
                pwc_pkg::KIND_CTRL: begin
                    nxt_st.prdata[pwc_pkg::BIT_EN]  = st_ff.en[ch];
                    nxt_st.prdata[pwc_pkg::BIT_OE]  = st_ff.oe[ch];
                    nxt_st.prdata[pwc_pkg::BIT_OUT] = st_ff.pin[ch]; // R3
                    nxt_st.prdata[pwc_pkg::BIT_INV] = st_ff.inv[ch];
                end
                pwc_pkg::KIND_DCH: begin
                    nxt_st.prdata[7:0] = kp_ff.dch[ch]; // R7
                end
                pwc_pkg::KIND_DCL: begin
                    nxt_st.prdata[7:6] = kp_ff.dcl[ch]; // R8
                end
                default: begin
                    nxt_st.pslverr = 1'b1;
                end
            endcase
        end

        // Writes land on the edge that completes the access
        if (commit & pwrite & pstrb[0]) begin
            case (kind)
                pwc_pkg::KIND_CTRL: begin
                    nxt_st.en[ch]  = pwdata[pwc_pkg::BIT_EN];  // R1
                    nxt_st.oe[ch]  = pwdata[pwc_pkg::BIT_OE];  // R2
                    nxt_st.inv[ch] = pwdata[pwc_pkg::BIT_INV]; // R4
                end
                pwc_pkg::KIND_DCH: begin
                    nxt_kp.dch[ch] = pwdata[7:0]; // R7
                end
                pwc_pkg::KIND_DCL: begin
                    nxt_kp.dcl[ch] = pwdata[7:6]; // R8
                end
                default: begin
                    nxt_st.pslverr = 1'b0;
                end
            endcase
        end

        // Waveform per channel on the shared time base
        for (int i = 0; i < 4; i++) begin
            new_duty[i] = {kp_ff.dch[i], kp_ff.dcl[i]};
            full[i] = {1'b0, kp_ff.dbuf[i]} >= limit; // R13
            if (tb_restart) begin
                nxt_kp.dbuf[i] = new_duty[i]; // R12
                nxt_st.raw[i]  = new_duty[i] != 10'h000; // R11 R14
            end else if (tb_count == kp_ff.dbuf[i] && !full[i]) begin
                nxt_st.raw[i] = 1'b0; // R11
            end
            if (!st_ff.en[i]) begin
                nxt_st.raw[i] = 1'b0; // R1
            end
            nxt_st.pin[i] = nxt_st.raw[i] ^ nxt_st.inv[i]; // R15
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff.en      <= 4'h0; // R6
            st_ff.oe      <= 4'h0; // R6
            st_ff.inv     <= 4'h0; // R6
            st_ff.raw     <= 4'h0;
            st_ff.pin     <= 4'h0; // R3
            st_ff.pready  <= 1'b0;
            st_ff.pslverr <= 1'b0;
            st_ff.prdata  <= pwc_pkg::RDATA_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // No reset: contents start unknown and survive resets
    always_ff @(posedge pclk) begin
        kp_ff <= nxt_kp; // R9 R10
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata      = st_ff.prdata;
    assign pready      = st_ff.pready;
    assign pslverr     = st_ff.pslverr;
    assign pwm_pin_out = st_ff.pin;
    assign pwm_pin_oe  = st_ff.oe; // R2

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge pclk);
    endclocking

    default disable iff (!presetn);

    a_ctrl_low_zero: assert property ( // R5
        pready && reg_kind($past(paddr)) == pwc_pkg::KIND_CTRL
        |-> prdata[3:0] == 4'h0
    ) else $error("control low bits not zero");

    a_dcl_low_zero: assert property ( // R8
        pready && reg_kind($past(paddr)) == pwc_pkg::KIND_DCL
        |-> prdata[5:0] == 6'h00
    ) else $error("duty low bits 5..0 not zero");

    a_oe_stays: assert property ( // R2
        !(commit && pwrite && pstrb[0] && kind == pwc_pkg::KIND_CTRL)
        |=> $stable(pwm_pin_oe)
    ) else $error("pin enable changed without a write");

    a_ctrl_stays: assert property ( // R1
        !(commit && pwrite && pstrb[0] && kind == pwc_pkg::KIND_CTRL)
        |=> $stable(st_ff.en) && $stable(st_ff.inv)
    ) else $error("control bits changed without a write");

    a_duty_stays: assert property ( // R9
        !(commit && pwrite && pstrb[0])
        |=> $stable(kp_ff.dch) && $stable(kp_ff.dcl)
    ) else $error("duty bits changed without a write");

    for (genvar g = 0; g < 4; g++) begin : g_chk

        a_dis_inactive: assert property ( // R1
            !st_ff.en[g] |=> !st_ff.raw[g]
        ) else $error("disabled channel went active");

        a_oe_follows: assert property ( // R2
            commit && pwrite && pstrb[0] && ch == 2'(g)
            && kind == pwc_pkg::KIND_CTRL
            |=> pwm_pin_oe[g] == $past(pwdata[pwc_pkg::BIT_OE])
        ) else $error("pin enable does not follow write");

        a_pin_polarity: assert property ( // R15
            pwm_pin_out[g] == (st_ff.raw[g] ^ st_ff.inv[g])
        ) else $error("pin not polarity adjusted");

        a_inv_low: assert property ( // R4
            st_ff.inv[g] && st_ff.raw[g] |-> !pwm_pin_out[g]
        ) else $error("inverted active output not low");

        a_restart_set: assert property ( // R11
            tb_restart && st_ff.en[g] && new_duty[g] != 10'h000
            |=> st_ff.raw[g]
        ) else $error("output not set on restart");

        a_match_clear: assert property ( // R11
            st_ff.en[g] && !tb_restart && !full[g]
            && tb_count == kp_ff.dbuf[g]
            |=> !st_ff.raw[g]
        ) else $error("output not cleared at duty match");

        a_buf_hold: assert property ( // R12
            !tb_restart |=> $stable(kp_ff.dbuf[g])
        ) else $error("buffer changed outside period match");

        a_full_hold: assert property ( // R13
            st_ff.raw[g] && st_ff.en[g] && full[g] && !tb_restart
            |=> st_ff.raw[g]
        ) else $error("full duty output was cleared");

        a_zero_duty: assert property ( // R14
            tb_restart && new_duty[g] == 10'h000 |=> !st_ff.raw[g]
        ) else $error("zero duty went active");

        a_en_write: assert property ( // R1
            commit && pwrite && pstrb[0] && ch == 2'(g)
            && kind == pwc_pkg::KIND_CTRL
            |=> st_ff.en[g] == $past(pwdata[pwc_pkg::BIT_EN])
        ) else $error("enable does not follow write");

        a_inv_write: assert property ( // R4
            commit && pwrite && pstrb[0] && ch == 2'(g)
            && kind == pwc_pkg::KIND_CTRL
            |=> st_ff.inv[g] == $past(pwdata[pwc_pkg::BIT_INV])
        ) else $error("invert does not follow write");

        a_dch_write: assert property ( // R7
            commit && pwrite && pstrb[0] && ch == 2'(g)
            && kind == pwc_pkg::KIND_DCH
            |=> kp_ff.dch[g] == $past(pwdata[7:0])
        ) else $error("duty high does not follow write");

        a_dcl_write: assert property ( // R8
            commit && pwrite && pstrb[0] && ch == 2'(g)
            && kind == pwc_pkg::KIND_DCL
            |=> kp_ff.dcl[g] == $past(pwdata[7:6])
        ) else $error("duty low does not follow write");

        a_status_read: assert property ( // R3
            pready && $past(paddr[5:4]) == 2'(g)
            && reg_kind($past(paddr)) == pwc_pkg::KIND_CTRL
            |-> prdata[pwc_pkg::BIT_OUT] == $past(pwm_pin_out[g])
        ) else $error("status bit does not show the pin");

        a_dch_read: assert property ( // R7
            pready && !$past(pwrite) && $past(paddr[5:4]) == 2'(g)
            && reg_kind($past(paddr)) == pwc_pkg::KIND_DCH
            |-> prdata[7:0] == $past(kp_ff.dch[g])
        ) else $error("duty high read does not match");

        a_dcl_read: assert property ( // R8
            pready && !$past(pwrite) && $past(paddr[5:4]) == 2'(g)
            && reg_kind($past(paddr)) == pwc_pkg::KIND_DCL
            |-> prdata[7:6] == $past(kp_ff.dcl[g])
        ) else $error("duty low read does not match");

        a_buf_load: assert property ( // R12
            tb_restart && st_ff.en[g]
            |=> kp_ff.dbuf[g] == $past(new_duty[g])
        ) else $error("buffer not loaded at period start");

        a_dis_pin: assert property ( // R15
            !st_ff.en[g] |=> pwm_pin_out[g] == st_ff.inv[g]
        ) else $error("disabled channel pin not inactive");

    end

endmodule // pwc_channels

/* File: rtl/pwc_pkg.sv */
// Constants shared by the four-channel pulse-width block.
// Assumes an APB master on pclk and a timer block on the same clock.

package pwc_pkg;

    ////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int unsigned CH_N   = 4;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DUTY_W = 10;

    ////////////////////////////////////////////////////////////////////
    // Register map: channel n sits at n * CH_STRIDE
    localparam logic [11:0] CH_STRIDE = 12'h010;
    localparam logic [3:0]  OFS_CTRL  = 4'h0;
    localparam logic [3:0]  OFS_DCH   = 4'h4;
    localparam logic [3:0]  OFS_DCL   = 4'h8;

    ////////////////////////////////////////////////////////////////////
    // Control field positions
    localparam int unsigned BIT_EN  = 7;
    localparam int unsigned BIT_OE  = 6;
    localparam int unsigned BIT_OUT = 5;
    localparam int unsigned BIT_INV = 4;

    // Duty low field position
    localparam int unsigned DCL_LSB = 6;

    ////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0]  CTRL_RST  = 8'h00;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////
    // Register kinds found by the decoder
    typedef enum logic [3:0] {
        KIND_CTRL = 4'h1,
        KIND_DCH  = 4'h2,
        KIND_DCL  = 4'h4,
        KIND_NONE = 4'h8
    } pwc_kind_t;

endpackage

/* File: dv/pwc_timebase_model.sv */
// Shared time base and pin model facing the four pulse-width channels.
// Assumes one clock; a pin whose driver is off is pulled up.
`timescale 1ns/1ps
module pwc_timebase_model (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Period and channel pins
    input  wire logic [7:0] period_limit,
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    // Time base and pin levels
    output      logic [9:0] timebase_count,
    output      logic       restart,
    output      logic [3:0] pin_level
);
    ////////////////////////////////////////////////////////////////////
    // One count for all channels, wraps at the period match
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timebase_count <= 10'h000;
        end else if (timebase_count == {period_limit, 2'h3}) begin
            timebase_count <= 10'h000;
        end else begin
            timebase_count <= timebase_count + 10'h001;
        end
    end
    assign restart   = (timebase_count == 10'h000);
    assign pin_level = ~pin_oe | pin_out;
endmodule // pwc_timebase_model

/* File: dv/tb_pwc_channels.sv */
// Self-checking bench for the four pulse-width channels.
// Assumes an APB master here and the time base model on pclk.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_pwc_channels;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rdata_q;
    logic        pready;
    logic        pslverr;
    logic        err_q;
    logic        restart;
    logic [9:0]  tb_count;
    logic [3:0]  pin_out;
    logic [3:0]  pin_oe;
    logic [3:0]  pin_level;
    logic [6:0]  acc_ff [4];
    logic [6:0]  last_ff [4];
    int          fails = 0;
    int          samples_checked = 0;
    int          cyc = 0;

    pwc_channels dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'hf), .prdata, .pready, .pslverr, .tb_count, .tb_period(8'h0f),
        .tb_restart(restart), .pwm_pin_out(pin_out), .pwm_pin_oe(pin_oe));
    pwc_timebase_model tbm (.pclk, .presetn, .period_limit(8'h0f), .pin_out, .pin_oe,
        .timebase_count(tb_count), .restart, .pin_level);

    initial forever #12.5 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////
    // Timeout and per-period count of high pin cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            report_and_stop();
        end
        for (int i = 0; i < 4; i++) begin
            acc_ff[i] <= restart ? 7'(pin_level[i]) : acc_ff[i] + 7'(pin_level[i]);
            if (restart) last_ff[i] <= acc_ff[i];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Bus helpers
    function automatic logic [11:0] adr(input int ch, input int o);
        return 12'(16 * ch + o);
    endfunction

    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata_q = prdata;
        err_q   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic duty(input int ch, input logic [9:0] d);
        apb(1'b1, adr(ch, 4), d[9:2]);
        apb(1'b1, adr(ch, 8), {d[1:0], 6'h00});
    endtask

    task automatic wait_restart;
        do @(negedge pclk); while (restart !== 1'b1);
        @(negedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        for (int ch = 0; ch < 4; ch++) begin
            apb(1'b0, adr(ch, 0), 8'h00);
            `CHK(rdata_q, 32'h0)
        end
        `CHK({pin_oe, pin_out}, 8'h00)
        apb(1'b0, 12'h040, 8'h00);
        `CHK({err_q, rdata_q}, 33'h1_0000_0000)
    endtask

    task automatic t_regs;
        apb(1'b1, adr(2, 4), 8'ha5);
        apb(1'b0, adr(2, 4), 8'h00);
        `CHK(rdata_q, 32'ha5)
        apb(1'b1, adr(2, 8), 8'hff);
        apb(1'b0, adr(2, 8), 8'h00);
        `CHK(rdata_q, 32'hc0)
        apb(1'b1, adr(2, 0), 8'h3f);
        apb(1'b0, adr(2, 0), 8'h00);
        `CHK(rdata_q, 32'h30)
        `CHK(pin_out[2], 1'b1)
    endtask

    task automatic t_wave;
        logic [9:0] dv [4] = '{10'd24, 10'd0, 10'd64, 10'd24};
        for (int ch = 0; ch < 4; ch++) begin
            duty(ch, dv[ch]);
            apb(1'b1, adr(ch, 0), (ch == 3) ? 8'hd0 : 8'hc0);
        end
        repeat (3) wait_restart;
        `CHK(pin_oe, 4'hf)
        `CHK(last_ff[0], 7'd24)
        `CHK(last_ff[1], 7'd0)
        `CHK(last_ff[2], 7'd64)
        `CHK(last_ff[3], 7'd40)
    endtask

    task automatic t_buffer;
        wait_restart;
        duty(0, 10'd40);
        wait_restart;
        `CHK(last_ff[0], 7'd24)
        wait_restart;
        `CHK(last_ff[0], 7'd40)
    endtask

    task automatic t_disable;
        apb(1'b1, adr(0, 0), 8'h40);
        apb(1'b0, adr(0, 0), 8'h00);
        `CHK(rdata_q, 32'h40)
        repeat (2) wait_restart;
        `CHK(last_ff[0], 7'd0)
        apb(1'b1, adr(0, 0), 8'h00);
        repeat (2) @(negedge pclk);
        `CHK({pin_oe[0], pin_level[0]}, 2'b01)
    endtask

    task automatic t_reset_mid;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, adr(2, 4), 8'h00);
        `CHK(rdata_q, 32'h10)
        apb(1'b0, adr(3, 0), 8'h00);
        `CHK(rdata_q, 32'h0)
    endtask

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_regs;
        t_wave;
        t_buffer;
        t_disable;
        t_reset_mid;
        report_and_stop;
    end
endmodule // tb_pwc_channels
